// >>> hw/ddr3_command_timing_guard.sv
// Host-side guard that spaces DDR3 commands and drives clock enable / ODT.
// Assumes a scheduler offers one command per cycle with a valid/ready handshake.
`timescale 1ns/1ns
`default_nettype none
module ddr3_command_timing_guard (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              cmd_valid,
  input  wire ddr3_timing_pkg::cmd_e             cmd_code,
  input  wire logic [ddr3_timing_pkg::BANK_W-1:0] cmd_bank,
  input  wire logic                              cmd_bc4,
  input  wire logic                              cmd_dll_frozen,
  input  wire logic                              cmd_needs_dll,
  input  wire logic                              wl_start,
  input  wire logic [3:0]                        read_latency,
  input  wire logic [3:0]                        write_latency,
  output logic                                   cmd_ready,
  output logic                                   cmd_issue,
  output ddr3_timing_pkg::cmd_e                  mem_cmd,
  output logic [ddr3_timing_pkg::BANK_W-1:0]     mem_bank,
  output logic                                   mem_cke,
  output logic                                   mem_odt,
  output logic                                   wl_strobe_ok,
  output logic                                   wl_driver_ok
);
  localparam int CW = ddr3_timing_pkg::CW;
  typedef logic [CW-1:0] cnt_t;

  // Global down-counters, one per constraint class
  cnt_t any_reg, dll_reg, mrd_reg, ccd_reg, rrd_reg, wtr_reg, pden_reg, cke_reg, odt_reg, wl_reg;
  cnt_t mod_reg;
  cnt_t rtp_reg [ddr3_timing_pkg::BANKS];
  cnt_t faw_reg [4];
  logic [1:0] faw_ptr_reg;
  logic cke_reg_q, sr_reg, pd_reg, odt_q;
  ddr3_timing_pkg::cmd_e mem_cmd_reg;
  logic [ddr3_timing_pkg::BANK_W-1:0] mem_bank_reg;

  function automatic cnt_t mx(input cnt_t a, input int b);
    return (a > cnt_t'(b)) ? a : cnt_t'(b);
  endfunction : mx
  function automatic cnt_t dec(input cnt_t a);
    return (a != '0) ? a - cnt_t'(1) : a;
  endfunction : dec
  // A gap of N loaded at the issue edge ends on the Nth edge after it
  function automatic logic fin(input cnt_t a);
    return a <= cnt_t'(1);
  endfunction : fin

  wire is_rd  = (cmd_code == ddr3_timing_pkg::CMD_RD) || (cmd_code == ddr3_timing_pkg::CMD_RDA);
  wire is_wr  = (cmd_code == ddr3_timing_pkg::CMD_WR) || (cmd_code == ddr3_timing_pkg::CMD_WRA);
  wire is_act = cmd_code == ddr3_timing_pkg::CMD_ACT;
  wire is_pre = cmd_code == ddr3_timing_pkg::CMD_PRE;
  wire is_mrs = cmd_code == ddr3_timing_pkg::CMD_MRS;
  wire is_pde = (cmd_code == ddr3_timing_pkg::CMD_PDE) || (cmd_code == ddr3_timing_pkg::CMD_SRE);
  wire is_pdx = (cmd_code == ddr3_timing_pkg::CMD_PDX) || (cmd_code == ddr3_timing_pkg::CMD_SRX);
  wire powered_down = sr_reg | pd_reg;

  // Each check passes on the edge its counter reaches zero
  wire ok_any  = fin(any_reg);
  wire ok_dll  = !cmd_needs_dll || fin(dll_reg);
  wire ok_mrs  = !is_mrs || fin(mrd_reg);
  wire ok_col  = !(is_rd || is_wr) || fin(ccd_reg);
  wire ok_wtr  = !is_rd || fin(wtr_reg);
  wire ok_rtp  = !is_pre || fin(rtp_reg[cmd_bank]);
  wire ok_act  = !is_act || (fin(rrd_reg) && fin(faw_reg[faw_ptr_reg]));
  wire ok_pde  = !is_pde || (fin(pden_reg) && fin(cke_reg));
  wire ok_pdx  = !is_pdx || fin(cke_reg);
  wire ok_odt  = fin(odt_reg) || !(is_pde);
  wire ok_state = powered_down ? is_pdx : !is_pdx;
  wire ok_mod  = is_mrs || fin(mod_reg);

  assign cmd_ready = ok_any & ok_dll & ok_mrs & ok_col & ok_wtr & ok_rtp & ok_act & ok_pde
                     & ok_pdx & ok_odt & ok_state & ok_mod;
  assign cmd_issue = cmd_valid & cmd_ready & (cmd_code != ddr3_timing_pkg::CMD_NOP);

  wire [CW-1:0] wr_burst = cmd_bc4 ? cnt_t'(ddr3_timing_pkg::N_BURST4)
                                   : cnt_t'(ddr3_timing_pkg::N_BURST8);
  wire [CW-1:0] wr_pden = cnt_t'(write_latency) + wr_burst + cnt_t'(
                 (cmd_code == ddr3_timing_pkg::CMD_WRA) ? ddr3_timing_pkg::N_DAL + 1
                                                        : ddr3_timing_pkg::N_WR);
  wire [CW-1:0] rd_pden = cnt_t'(read_latency) + cnt_t'(5);
  wire [CW-1:0] wr_wtr  = cnt_t'(write_latency) + wr_burst + cnt_t'(ddr3_timing_pkg::N_WTR);

  logic [CW-1:0] any_next;
  always_comb begin
    any_next = dec(any_reg);
    if (cmd_issue) begin
      case (cmd_code)
        ddr3_timing_pkg::CMD_MRS:       any_next = mx(any_next, ddr3_timing_pkg::N_MRD);
        ddr3_timing_pkg::CMD_ZQCL_INIT: any_next = mx(any_next, ddr3_timing_pkg::N_ZQINIT);
        ddr3_timing_pkg::CMD_ZQCL:      any_next = mx(any_next, ddr3_timing_pkg::N_ZQOPER);
        ddr3_timing_pkg::CMD_ZQCS:      any_next = mx(any_next, ddr3_timing_pkg::N_ZQCS);
        ddr3_timing_pkg::CMD_SRX:       any_next = mx(any_next, ddr3_timing_pkg::N_XPR);
        ddr3_timing_pkg::CMD_PDX:       any_next = mx(any_next, ddr3_timing_pkg::N_XP);
        default:                        any_next = any_next;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      any_reg <= cnt_t'(ddr3_timing_pkg::N_XPR);
      dll_reg <= '0;
      mrd_reg <= '0;
      mod_reg <= '0;
      ccd_reg <= '0;
      rrd_reg <= '0;
      wtr_reg <= '0;
      pden_reg <= '0;
      cke_reg <= cnt_t'(ddr3_timing_pkg::N_CKSRE);
      odt_reg <= '0;
      faw_ptr_reg <= '0;
      sr_reg <= 1'b0;
      pd_reg <= 1'b0;
      cke_reg_q <= 1'b1;
      odt_q <= 1'b0;
      mem_cmd_reg <= ddr3_timing_pkg::CMD_NOP;
      mem_bank_reg <= '0;
    end else begin
      any_reg <= any_next;
      // A pending MRS blocks other commands for the update delay
      mrd_reg <= (cmd_issue && is_mrs) ? cnt_t'(ddr3_timing_pkg::N_MRD) : dec(mrd_reg);
      mod_reg <= (cmd_issue && is_mrs) ? cnt_t'(ddr3_timing_pkg::N_MOD) : dec(mod_reg);
      dll_reg <= (cmd_issue && cmd_code == ddr3_timing_pkg::CMD_SRX) ? cnt_t'(ddr3_timing_pkg::T_DLLK)
               : (cmd_issue && cmd_code == ddr3_timing_pkg::CMD_PDX && cmd_dll_frozen)
                 ? cnt_t'(ddr3_timing_pkg::N_XPDLL) : dec(dll_reg);
      ccd_reg <= (cmd_issue && (is_rd || is_wr)) ? cnt_t'(ddr3_timing_pkg::N_CCD) : dec(ccd_reg);
      rrd_reg <= (cmd_issue && is_act) ? cnt_t'(ddr3_timing_pkg::N_RRD) : dec(rrd_reg);
      wtr_reg <= (cmd_issue && is_wr) ? wr_wtr : dec(wtr_reg);
      if (cmd_issue && is_act)
        faw_ptr_reg <= faw_ptr_reg + 2'h1;
      if (cmd_issue && (is_act || is_pre || cmd_code == ddr3_timing_pkg::CMD_REF))
        pden_reg <= mx(dec(pden_reg), ddr3_timing_pkg::N_PDEN1);
      else if (cmd_issue && is_rd)
        pden_reg <= mx(dec(pden_reg), int'(rd_pden));
      else if (cmd_issue && is_wr)
        pden_reg <= mx(dec(pden_reg), int'(wr_pden));
      else if (cmd_issue && is_mrs)
        pden_reg <= mx(dec(pden_reg), ddr3_timing_pkg::N_MOD);
      else
        pden_reg <= dec(pden_reg);
      if (cmd_issue && (is_pde || is_pdx)) begin
        cke_reg_q <= is_pdx;
        cke_reg <= cnt_t'((cmd_code == ddr3_timing_pkg::CMD_SRE) ? ddr3_timing_pkg::N_CKESR
                                                                 : ddr3_timing_pkg::N_CKE);
      end else begin
        cke_reg <= dec(cke_reg);
      end
      if (cmd_issue && cmd_code == ddr3_timing_pkg::CMD_SRE)
        sr_reg <= 1'b1;
      else if (cmd_issue && cmd_code == ddr3_timing_pkg::CMD_SRX)
        sr_reg <= 1'b0;
      if (cmd_issue && cmd_code == ddr3_timing_pkg::CMD_PDE)
        pd_reg <= 1'b1;
      else if (cmd_issue && cmd_code == ddr3_timing_pkg::CMD_PDX)
        pd_reg <= 1'b0;
      // ODT raised with each write, held for the burst-dependent minimum
      if (cmd_issue && is_wr) begin
        odt_q <= 1'b1;
        odt_reg <= cnt_t'(cmd_bc4 ? ddr3_timing_pkg::N_ODTH4 : ddr3_timing_pkg::N_ODTH8);
      end else begin
        odt_reg <= dec(odt_reg);
        if (odt_reg <= cnt_t'(1))
          odt_q <= 1'b0;
      end
      mem_cmd_reg <= cmd_issue ? cmd_code : ddr3_timing_pkg::CMD_NOP;
      mem_bank_reg <= cmd_issue ? cmd_bank : mem_bank_reg;
    end
  end

  // Per-bank read/write-to-precharge spacing
  genvar b;
  generate
    for (b = 0; b < ddr3_timing_pkg::BANKS; b++) begin : g_bank
      wire hit = cmd_issue && (cmd_bank == (ddr3_timing_pkg::BANK_W)'(b));
      always_ff @(posedge clk) begin
        if (rst)
          rtp_reg[b] <= '0;
        else if (hit && is_rd)
          rtp_reg[b] <= mx(dec(rtp_reg[b]), ddr3_timing_pkg::N_RTP);
        else if (hit && is_wr)
          rtp_reg[b] <= mx(dec(rtp_reg[b]), int'(wr_burst) + int'(write_latency)
                           + ddr3_timing_pkg::N_WR);
        else
          rtp_reg[b] <= dec(rtp_reg[b]);
      end
    end
  endgenerate

  // Oldest of the last four activates must have aged out
  genvar f;
  generate
    for (f = 0; f < 4; f++) begin : g_faw
      always_ff @(posedge clk) begin
        if (rst)
          faw_reg[f] <= '0;
        else if (cmd_issue && is_act && faw_ptr_reg == 2'(f))
          faw_reg[f] <= cnt_t'(ddr3_timing_pkg::N_FAW);
        else
          faw_reg[f] <= dec(faw_reg[f]);
      end
    end
  endgenerate

  // Write-leveling gate counter
  always_ff @(posedge clk) begin
    if (rst)
      wl_reg <= '0;
    else if (wl_start)
      wl_reg <= cnt_t'(ddr3_timing_pkg::N_WLMRD);
    else
      wl_reg <= dec(wl_reg);
  end
  assign wl_strobe_ok = (wl_reg == '0);
  assign wl_driver_ok = (wl_reg <= cnt_t'(ddr3_timing_pkg::N_WLMRD - ddr3_timing_pkg::N_WLDQSEN));

  assign mem_cmd  = mem_cmd_reg;
  assign mem_bank = mem_bank_reg;
  assign mem_cke  = cke_reg_q;
  assign mem_odt  = odt_q;
endmodule : ddr3_command_timing_guard
`default_nettype wire

// >>> include/ddr3_timing_pkg.sv
// Timing constants for the DDR3 command-spacing guard.
// Assumes one 50 MHz clock; ns limits round up to whole cycles.
`default_nettype none
package ddr3_timing_pkg;
  localparam int CLK_PERIOD_PS = 20000;
  localparam int CW = 10;
  localparam int BANKS = 8;
  localparam int BANK_W = 3;
  // Round-up conversion of picoseconds to cycles, at least the cycle floor
  function automatic int cyc(input int floor_nck, input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c > floor_nck) ? c : floor_nck;
  endfunction : cyc
  localparam int T_DLLK = 512;
  localparam int T_RTP_PS = 7500;
  localparam int T_WTR_PS = 7500;
  localparam int T_WR_PS = 15000;
  localparam int T_RP_PS = 13125;
  localparam int T_MOD_PS = 15000;
  localparam int T_RRD_PS = 10000;
  localparam int T_FAW_PS = 40000;
  localparam int T_RFC_PS = 110000;
  localparam int T_XPR_EXTRA_PS = 10000;
  localparam int T_CKSRE_PS = 10000;
  localparam int T_XP_PS = 7500;
  localparam int T_XPDLL_PS = 24000;
  localparam int T_CKE_PS = 7500;
  localparam int N_RTP = cyc(4, T_RTP_PS);
  localparam int N_WTR = cyc(4, T_WTR_PS);
  localparam int N_WR = cyc(1, T_WR_PS);
  localparam int N_DAL = N_WR + cyc(1, T_RP_PS);
  localparam int N_MRD = 4;
  localparam int N_MOD = cyc(12, T_MOD_PS);
  localparam int N_CCD = 4;
  localparam int N_RRD = cyc(4, T_RRD_PS);
  localparam int N_FAW = cyc(1, T_FAW_PS);
  localparam int N_XPR = cyc(5, T_RFC_PS + T_XPR_EXTRA_PS);
  localparam int N_ZQINIT = 512;
  localparam int N_ZQOPER = 256;
  localparam int N_ZQCS = 64;
  localparam int N_CKSRE = cyc(5, T_CKSRE_PS);
  localparam int N_XP = cyc(3, T_XP_PS);
  localparam int N_XPDLL = cyc(10, T_XPDLL_PS);
  localparam int N_CKE = cyc(3, T_CKE_PS);
  localparam int N_CKESR = N_CKE + 1;
  localparam int N_PDEN1 = 1;
  localparam int N_BURST8 = 4;
  localparam int N_BURST4 = 2;
  localparam int N_ODTH4 = 4;
  localparam int N_ODTH8 = 6;
  localparam int N_WLMRD = 40;
  localparam int N_WLDQSEN = 25;
  localparam logic [3:0] CL_DEFAULT = 4'h5;
  localparam logic [3:0] CWL_DEFAULT = 4'h5;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_PRE, CMD_REF,
    CMD_MRS, CMD_ZQCL_INIT, CMD_ZQCL, CMD_ZQCS, CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX
  } cmd_e;
endpackage : ddr3_timing_pkg
`default_nettype wire

// >>> tb/ddr3_device_model.sv
// Behavioural DDR3 device on the guard's memory side.
// Counts spacing faults; sees at most one command a cycle.
`timescale 1ns/1ns
`default_nettype none
module ddr3_device_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ddr3_timing_pkg::cmd_e mem_cmd,
  output int                         violations
);
  int mrs_age, col_age, act_age, srx_age;
  // Ages count real clock edges, so jitter cannot shorten a gap
  wire locked = srx_age >= ddr3_timing_pkg::T_DLLK;
  wire col = mem_cmd inside {ddr3_timing_pkg::CMD_RD, ddr3_timing_pkg::CMD_RDA,
    ddr3_timing_pkg::CMD_WR, ddr3_timing_pkg::CMD_WRA};
  wire is_mrs = mem_cmd == ddr3_timing_pkg::CMD_MRS;
  wire is_act = mem_cmd == ddr3_timing_pkg::CMD_ACT;
  wire bad = (is_mrs && mrs_age < ddr3_timing_pkg::N_MRD) ||
    (col && (col_age < ddr3_timing_pkg::N_CCD || !locked)) ||
    (is_act && act_age < ddr3_timing_pkg::N_RRD);
  always_ff @(posedge clk) begin
    if (rst) begin
      mrs_age <= 99;
      col_age <= 99;
      act_age <= 99;
      srx_age <= 999;
      violations <= 0;
    end else begin
      mrs_age <= is_mrs ? 1 : mrs_age + 1;
      col_age <= col ? 1 : col_age + 1;
      act_age <= is_act ? 1 : act_age + 1;
      srx_age <= (mem_cmd == ddr3_timing_pkg::CMD_SRX) ? 1 : srx_age + 1;
      violations <= violations + int'(bad);
    end
  end
endmodule : ddr3_device_model
`default_nettype wire

// >>> tb/ddr3_guard_asserts.sv
// Port-level timing checks for the DDR3 command guard.
// Bound into every guard instance; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
module ddr3_guard_asserts (
  input wire logic                               clk,
  input wire logic                               rst,
  input wire ddr3_timing_pkg::cmd_e              cmd_code,
  input wire logic [ddr3_timing_pkg::BANK_W-1:0] cmd_bank,
  input wire logic                               cmd_issue,
  input wire ddr3_timing_pkg::cmd_e              mem_cmd,
  input wire logic [ddr3_timing_pkg::BANK_W-1:0] mem_bank,
  input wire logic                               mem_cke,
  input wire logic                               wl_start,
  input wire logic                               wl_driver_ok
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire is_mrs = cmd_issue && cmd_code == ddr3_timing_pkg::CMD_MRS;
  wire is_act = cmd_issue && cmd_code == ddr3_timing_pkg::CMD_ACT;
  wire is_col = cmd_issue && cmd_code inside {ddr3_timing_pkg::CMD_RD,
    ddr3_timing_pkg::CMD_RDA, ddr3_timing_pkg::CMD_WR, ddr3_timing_pkg::CMD_WRA};
  wire other = cmd_issue && !is_mrs;
  property p_echo;
    cmd_issue |=> mem_cmd == $past(cmd_code) && mem_bank == $past(cmd_bank);
  endproperty
  a_echo: assert property (p_echo) else $error("command not echoed");
  property p_mrd; is_mrs |=> !is_mrs [*3]; endproperty
  a_mrd: assert property (p_mrd) else $error("mode sets too close");
  property p_mod; is_mrs |=> !other [*8] ##1 !other [*3]; endproperty
  a_mod: assert property (p_mod) else $error("command inside mode update");
  property p_ccd; is_col |=> !is_col [*3]; endproperty
  a_ccd: assert property (p_ccd) else $error("column commands too close");
  property p_rrd; is_act |=> !is_act [*3]; endproperty
  a_rrd: assert property (p_rrd) else $error("activates too close");
  property p_xpr; $fell(rst) |-> !cmd_issue [*5]; endproperty
  a_xpr: assert property (p_xpr) else $error("command too soon after reset");
  property p_cke; $changed(mem_cke) |=> $stable(mem_cke) [*2]; endproperty
  a_cke: assert property (p_cke) else $error("clock enable pulse short");
  property p_wl; wl_start |=> !wl_driver_ok [*8]; endproperty
  a_wl: assert property (p_wl) else $error("strobe drivers enabled early");
  c_mrs: cover property (is_mrs ##4 is_mrs);
  c_act: cover property (is_act ##4 is_act);
  c_cke: cover property ($fell(mem_cke));
endmodule : ddr3_guard_asserts
bind ddr3_command_timing_guard ddr3_guard_asserts u_chk (.clk(clk), .rst(rst),
  .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_issue(cmd_issue), .mem_cmd(mem_cmd),
  .mem_bank(mem_bank), .mem_cke(mem_cke), .wl_start(wl_start), .wl_driver_ok(wl_driver_ok));
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the DDR3 command guard at 50 MHz.
// Device model watches the memory side; the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_needs_dll = 1'b0, wl_start = 1'b0;
  logic cmd_ready, cmd_issue, mem_cke, mem_odt, wl_strobe_ok, wl_driver_ok, pend = 1'b0;
  logic [ddr3_timing_pkg::BANK_W-1:0] cmd_bank = '0, mem_bank;
  ddr3_timing_pkg::cmd_e cmd_code = ddr3_timing_pkg::CMD_NOP, mem_cmd, pend_code;
  logic [15:0] gap;
  int errors = 0, n_compared = 0, violations;
  ddr3_command_timing_guard uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_bc4(1'b0), .cmd_dll_frozen(1'b0),
    .cmd_needs_dll(cmd_needs_dll), .wl_start(wl_start), .read_latency(4'h5),
    .write_latency(4'h5), .cmd_ready(cmd_ready), .cmd_issue(cmd_issue), .mem_cmd(mem_cmd),
    .mem_bank(mem_bank), .mem_cke(mem_cke), .mem_odt(mem_odt),
    .wl_strobe_ok(wl_strobe_ok), .wl_driver_ok(wl_driver_ok));
  ddr3_device_model dev (.clk(clk), .rst(rst), .mem_cmd(mem_cmd), .violations(violations));
  initial forever #10 clk = ~clk;
  task automatic check(input string what, input int exp, input logic [15:0] got);
    n_compared++;
    if (got !== 16'(exp)) begin
      errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Called on an edge; returns on the edge that takes the command
  task automatic send(input ddr3_timing_pkg::cmd_e code,
                      input logic [ddr3_timing_pkg::BANK_W-1:0] bank);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_bank <= bank;
    gap = '0;
    #1;
    if (pend === 1'b1) check("mem_cmd", int'(pend_code), {12'h0, mem_cmd});
    while (cmd_ready !== 1'b1 && gap < 16'h0258) begin
      @(posedge clk);
      #1;
      gap++;
    end
    pend = 1'b1;
    pend_code = code;
    if (cmd_ready !== 1'b1) begin
      errors++;
      $display("unexpected cmd_ready: expected 1, seen %b", cmd_ready);
      print_verdict();
    end
    @(posedge clk);
  endtask : send
  task automatic idle();
    cmd_valid <= 1'b0;
    cmd_code <= ddr3_timing_pkg::CMD_NOP;
    cmd_needs_dll <= 1'b0;
    pend = 1'b0;
    @(posedge clk);
    #1;
  endtask : idle
  task automatic test_mode();
    send(ddr3_timing_pkg::CMD_MRS, 3'h0);
    send(ddr3_timing_pkg::CMD_MRS, 3'h0);
    check("mode set gap", ddr3_timing_pkg::N_MRD - 1, gap);
    send(ddr3_timing_pkg::CMD_ACT, 3'h0);
    check("mode update gap", ddr3_timing_pkg::N_MOD - 1, gap);
    for (int b = 1; b < 5; b++) begin
      send(ddr3_timing_pkg::CMD_ACT, b[2:0]);
      check("activate gap", ddr3_timing_pkg::N_RRD - 1, gap);
    end
    $display("mode test done");
  endtask : test_mode
  task automatic test_column();
    send(ddr3_timing_pkg::CMD_RD, 3'h0);
    send(ddr3_timing_pkg::CMD_RD, 3'h1);
    check("column gap", ddr3_timing_pkg::N_CCD - 1, gap);
    send(ddr3_timing_pkg::CMD_PRE, 3'h1);
    check("read to precharge gap", ddr3_timing_pkg::N_RTP - 1, gap);
    send(ddr3_timing_pkg::CMD_WR, 3'h2);
    send(ddr3_timing_pkg::CMD_RD, 3'h2);
    check("write to read gap",
          5 + ddr3_timing_pkg::N_BURST8 + ddr3_timing_pkg::N_WTR - 1, gap);
    $display("column test done");
  endtask : test_column
  task automatic test_calib();
    ddr3_timing_pkg::cmd_e zq [3];
    int span [3];
    zq = '{ddr3_timing_pkg::CMD_ZQCS, ddr3_timing_pkg::CMD_ZQCL, ddr3_timing_pkg::CMD_ZQCL_INIT};
    span = '{ddr3_timing_pkg::N_ZQCS, ddr3_timing_pkg::N_ZQOPER, ddr3_timing_pkg::N_ZQINIT};
    for (int i = 0; i < 3; i++) begin
      send(zq[i], 3'h0);
      send(ddr3_timing_pkg::CMD_REF, 3'h0);
      check("calibration gap", span[i] - 1, gap);
    end
    $display("calibration test done");
  endtask : test_calib
  task automatic test_power();
    send(ddr3_timing_pkg::CMD_PDE, 3'h0);
    idle();
    check("mem_cke", 0, {15'h0, mem_cke});
    @(posedge clk);
    send(ddr3_timing_pkg::CMD_PDX, 3'h0);
    send(ddr3_timing_pkg::CMD_ACT, 3'h5);
    check("power-down exit gap", ddr3_timing_pkg::N_XP - 1, gap);
    send(ddr3_timing_pkg::CMD_SRE, 3'h0);
    send(ddr3_timing_pkg::CMD_SRX, 3'h0);
    send(ddr3_timing_pkg::CMD_REF, 3'h0);
    check("self-refresh exit gap", ddr3_timing_pkg::N_XPR - 1, gap);
    cmd_needs_dll <= 1'b1;
    send(ddr3_timing_pkg::CMD_RD, 3'h0);
    check("lock wait", ddr3_timing_pkg::T_DLLK - ddr3_timing_pkg::N_XPR - 1, gap);
    idle();
    check("mem_cke", 1, {15'h0, mem_cke});
    $display("power test done");
  endtask : test_power
  task automatic test_wl();
    @(posedge clk);
    wl_start <= 1'b1;
    @(posedge clk);
    wl_start <= 1'b0;
    gap = '0;
    #1;
    while (wl_driver_ok !== 1'b1 && gap < 16'h0064) begin
      @(posedge clk);
      #1;
      gap++;
    end
    check("driver enable delay", ddr3_timing_pkg::N_WLDQSEN, gap);
    while (wl_strobe_ok !== 1'b1 && gap < 16'h0064) begin
      @(posedge clk);
      #1;
      gap++;
    end
    check("first strobe delay", ddr3_timing_pkg::N_WLMRD, gap);
    $display("leveling test done");
  endtask : test_wl
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset cke", 1, {15'h0, mem_cke});
    check("reset odt", 0, {15'h0, mem_odt});
    @(posedge clk);
    test_mode();
    test_column();
    test_calib();
    test_power();
    test_wl();
    check("device faults", 0, 16'(violations));
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
